// ==== core/psw_pkg.sv ====
// Shared constants and types of the instruction sequencing block
package psw_pkg;

  // ****************************************************************
  // Status word field positions (bit 0 of a word is its lsb)
  // ****************************************************************
  localparam int unsigned SMASK_HI = 31;
  localparam int unsigned SMASK_LO = 24;
  localparam int unsigned KEY_HI = 23;
  localparam int unsigned KEY_LO = 20;
  localparam int unsigned ASCII_BIT = 19;
  localparam int unsigned MCHK_BIT = 18;
  localparam int unsigned WAIT_BIT = 17;
  localparam int unsigned PROB_BIT = 16;
  localparam int unsigned ICODE_HI = 15;
  localparam int unsigned ILC_HI = 31;
  localparam int unsigned ILC_LO = 30;
  localparam int unsigned CC_HI = 29;
  localparam int unsigned CC_LO = 28;
  localparam int unsigned PMASK_HI = 27;
  localparam int unsigned PMASK_LO = 24;
  localparam int unsigned IA_HI = 23;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned GR_COMP_HI = 23;

  // ****************************************************************
  // Reset values and fixed quantities
  // ****************************************************************
  localparam logic [31:0] PSW1_RST = 32'h0000_0000;
  localparam logic [31:0] PSW2_RST = 32'h0000_0000;
  localparam logic [23:0] ZERO_ADDR = 24'h00_0000;
  localparam logic [23:0] HALF_STEP = 24'h00_0002;
  localparam logic [23:0] FULL_STEP = 24'h00_0004;
  localparam logic [23:0] HALF_ALIGN = 24'hff_fffe;
  localparam logic [1:0] STATUS_LOAD_INSTR_LAST = 2'h3;
  localparam logic [1:0] ILC_ONE = 2'h1;
  localparam logic [1:0] ILC_TWO = 2'h2;

  // ****************************************************************
  // Opcode assignments
  // ****************************************************************
  localparam logic [7:0] OP_COND_BRANCH_REG = 8'h07;
  localparam logic [7:0] OP_COND_BRANCH = 8'h47;
  localparam logic [7:0] OP_PROG_MASK_SET = 8'h04;
  localparam logic [7:0] OP_SUP_CALL = 8'h0a;
  localparam logic [7:0] OP_SYS_MASK_SET = 8'h80;
  localparam logic [7:0] OP_STATUS_LOAD = 8'h82;
  localparam logic [7:0] OP_IO_START = 8'h8c;
  localparam logic [7:0] OP_IO_TEST = 8'h8d;
  localparam logic [7:0] OP_IO_HALT = 8'h8e;
  localparam logic [7:0] OP_CHAN_TEST = 8'h8f;
  // One bit per opcode: 64 standard codes and 44 floating codes
  localparam logic [255:0] STD_OP_MAP = {112'h0, 16'hffff, 48'h0,
    16'hffff, 32'h0, 32'hffff_ffff};
  localparam logic [255:0] FP_OP_MAP = {164'h0, 12'hfff, 16'h0,
    32'hffff_ffff, 32'h0};

  typedef enum logic [1:0] {
    FMT_REG_REG = 2'b00,
    FMT_INDEXED = 2'b01,
    FMT_STORAGE = 2'b10,
    FMT_OTHER = 2'b11
  } psw_fmt_t;

  typedef enum logic [1:0] {
    IO_START = 2'b00,
    IO_TEST = 2'b01,
    IO_HALT = 2'b10,
    IO_CHAN_TEST = 2'b11
  } psw_io_kind_t;

endpackage

// ==== core/psw_decode.sv ====
// Opcode classifier: length, format and validity
`timescale 1ns/100ps
`default_nettype none
module psw_decode (
  input wire logic [7:0] opcode_i,
  input wire logic fp_present_i,
  output logic len2_o,
  output psw_pkg::psw_fmt_t fmt_o,
  output logic valid_o,
  output logic is_fp_o
);

  assign len2_o = (opcode_i[7:6] != 2'b00);
  assign fmt_o = psw_pkg::psw_fmt_t'(opcode_i[7:6]);
  assign is_fp_o = psw_pkg::FP_OP_MAP[opcode_i];
  // floating set only with the feature
  assign valid_o = psw_pkg::STD_OP_MAP[opcode_i] |
                   (psw_pkg::FP_OP_MAP[opcode_i] & fp_present_i);

endmodule
`default_nettype wire

// ==== core/psw_addr_gen.sv ====
// Operand address former: base plus index plus displacement
`timescale 1ns/100ps
`default_nettype none
module psw_addr_gen (
  input wire logic [3:0] base_fld_i,
  input wire logic [3:0] idx_fld_i,
  input wire logic use_idx_i,
  input wire logic [11:0] disp_i,
  input wire logic [31:0] base_val_i,
  input wire logic [31:0] idx_val_i,
  output logic [23:0] addr_o
);

  logic [23:0] base_c;
  logic [23:0] idx_c;

  assign base_c = (base_fld_i == 4'h0) ? psw_pkg::ZERO_ADDR
                : base_val_i[psw_pkg::GR_COMP_HI:0];
  assign idx_c = (!use_idx_i || idx_fld_i == 4'h0) ? psw_pkg::ZERO_ADDR
               : idx_val_i[psw_pkg::GR_COMP_HI:0];
  assign addr_o = base_c + idx_c + {12'h000, disp_i};

endmodule
`default_nettype wire

// ==== core/psw_seq.sv ====
// Instruction sequencer with the current program status word
`timescale 1ns/100ps
`default_nettype none
module psw_seq (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic fp_present_i,
  output logic mem_req_o,
  output logic [23:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic gr_we_i,
  input wire logic [3:0] gr_waddr_i,
  input wire logic [31:0] gr_wdata_i,
  output logic exec_start_o,
  output logic [7:0] exec_opcode_o,
  output logic [3:0] exec_r1_o,
  output logic [3:0] exec_r2_o,
  output logic [23:0] exec_addr_o,
  output logic exec_fp_o,
  input wire logic exec_done_i,
  input wire logic exec_cc_we_i,
  input wire logic [1:0] exec_cc_i,
  output logic io_start_o,
  output psw_pkg::psw_io_kind_t io_kind_o,
  output logic [23:0] io_addr_o,
  input wire logic io_done_i,
  input wire logic [1:0] io_cc_i,
  output logic prog_check_o,
  output logic svc_o,
  input wire logic intr_i,
  input wire logic [15:0] intr_code_i,
  input wire logic [63:0] intr_new_psw_i,
  output logic intr_ack_o,
  output logic [63:0] old_psw_o,
  output logic [63:0] psw_o,
  input wire logic [7:0] io_pend_i,
  output logic [7:0] irq_pend_o,
  input wire logic mcheck_i,
  output logic mcheck_irq_o
);

  // ****************************************************************
  // State and storage
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_NEXT = 7'b000_0001,
    ST_FETCH_HI = 7'b000_0010,
    ST_FETCH_LO = 7'b000_0100,
    ST_DISPATCH = 7'b000_1000,
    ST_MEM_RD = 7'b001_0000,
    ST_EXEC_WAIT = 7'b010_0000,
    ST_IO_WAIT = 7'b100_0000
  } psw_state_t;

  psw_state_t state;
  psw_state_t next_state;
  logic [31:0] psw1;
  logic [31:0] psw2;
  logic [31:0] gr [16];
  logic [15:0] ir_hi;
  logic [15:0] ir_lo;
  logic [63:0] load_buf;
  logic [1:0] rd_cnt;
  logic [23:0] op_addr;
  logic len2;
  psw_pkg::psw_fmt_t fmt;
  logic op_valid;
  logic op_fp;
  logic [7:0] op;
  logic [3:0] r1;
  logic [3:0] r2;
  logic take_mem;
  logic is_branch;
  logic br_taken;
  logic [23:0] br_target;
  logic is_io;
  logic is_status_load_instr;
  logic is_ssm;
  logic is_spm;
  logic is_svc;
  logic intr_go;
  logic fetch_go;
  logic rd_last;
  logic [23:0] ia;
  logic [1:0] cc;
  logic exec_addr_o_lsb;

  assign op = ir_hi[15:8];
  assign r1 = ir_hi[7:4];
  assign r2 = ir_hi[3:0];
  assign ia = psw2[psw_pkg::IA_HI:0];
  assign cc = psw2[psw_pkg::CC_HI:psw_pkg::CC_LO];
  assign take_mem = mem_req_o & mem_ack_i;
  assign psw_o = {psw1, psw2};
  assign intr_go = (state == ST_NEXT) && intr_i;
  assign fetch_go = (state == ST_NEXT) && !intr_i &&
                    !psw1[psw_pkg::WAIT_BIT];
  assign rd_last = is_ssm || (rd_cnt == psw_pkg::STATUS_LOAD_INSTR_LAST);

  psw_decode u_decode (
    .opcode_i(op),
    .fp_present_i(fp_present_i),
    .len2_o(len2),
    .fmt_o(fmt),
    .valid_o(op_valid),
    .is_fp_o(op_fp)
  );

  psw_addr_gen u_addr (
    .base_fld_i(ir_lo[15:12]),
    .idx_fld_i(r2),
    .use_idx_i(fmt == psw_pkg::FMT_INDEXED),
    .disp_i(ir_lo[11:0]),
    .base_val_i(gr[ir_lo[15:12]]),
    .idx_val_i(gr[r2]),
    .addr_o(op_addr)
  );

  assign is_branch = (op == psw_pkg::OP_COND_BRANCH_REG) ||
                     (op == psw_pkg::OP_COND_BRANCH);
  assign is_status_load_instr = (op == psw_pkg::OP_STATUS_LOAD);
  assign is_ssm = (op == psw_pkg::OP_SYS_MASK_SET);
  assign is_spm = (op == psw_pkg::OP_PROG_MASK_SET);
  assign is_svc = (op == psw_pkg::OP_SUP_CALL);
  // four I/O opcodes share one port
  assign is_io = (op[7:2] == psw_pkg::OP_IO_START[7:2]);
  // mask bit 0 stands for code 0
  assign br_taken = ir_hi[4'd7 - {2'b00, cc}];
  assign br_target = (fmt == psw_pkg::FMT_REG_REG)
                   ? gr[r2][psw_pkg::GR_COMP_HI:0] : op_addr;

  // ****************************************************************
  // Sequencing state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_NEXT: begin
        if (fetch_go) begin
          next_state = ST_FETCH_HI;
        end
      end
      ST_FETCH_HI: begin
        if (take_mem) begin
          next_state = (mem_rdata_i[15:14] != 2'b00) ? ST_FETCH_LO
                     : ST_DISPATCH;
        end
      end
      ST_FETCH_LO: begin
        if (take_mem) begin
          next_state = ST_DISPATCH;
        end
      end
      ST_DISPATCH: begin
        if (!op_valid || is_branch || is_spm || is_svc) begin
          next_state = ST_NEXT;
        end else if (is_status_load_instr || is_ssm) begin
          next_state = ST_MEM_RD;
        end else if (is_io) begin
          next_state = ST_IO_WAIT;
        end else begin
          next_state = ST_EXEC_WAIT;
        end
      end
      ST_MEM_RD: begin
        if (take_mem && rd_last) begin
          next_state = ST_NEXT;
        end
      end
      ST_EXEC_WAIT: begin
        if (exec_done_i) begin
          next_state = ST_NEXT;
        end
      end
      ST_IO_WAIT: begin
        if (io_done_i) begin
          next_state = ST_NEXT;
        end
      end
      default: begin
        next_state = ST_NEXT;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= ST_NEXT;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Storage port and instruction register
  // ****************************************************************
  // fetch at current address
  // no prefetch; fetch starts after completion
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= psw_pkg::ZERO_ADDR;
      ir_hi <= 16'h0000;
      ir_lo <= 16'h0000;
      rd_cnt <= 2'h0;
      load_buf <= 64'h0;
    end else begin
      if (take_mem) begin
        mem_req_o <= 1'b0;
      end
      if (fetch_go) begin
        mem_req_o <= 1'b1;
        mem_addr_o <= ia;
      end
      if (state == ST_FETCH_HI && take_mem) begin
        ir_hi <= mem_rdata_i;
        ir_lo <= 16'h0000;
        if (mem_rdata_i[15:14] != 2'b00) begin
          mem_req_o <= 1'b1;
          mem_addr_o <= ia + psw_pkg::HALF_STEP;
        end
      end
      if (state == ST_FETCH_LO && take_mem) begin
        ir_lo <= mem_rdata_i;
      end
      if (state == ST_DISPATCH && op_valid && (is_status_load_instr || is_ssm)) begin
        mem_req_o <= 1'b1;
        mem_addr_o <= op_addr & psw_pkg::HALF_ALIGN;
        rd_cnt <= 2'h0;
        exec_addr_o_lsb <= op_addr[0];
      end
      if (state == ST_MEM_RD && take_mem) begin
        load_buf <= {load_buf[47:0], mem_rdata_i};
        rd_cnt <= rd_cnt + 2'h1;
        if (!rd_last) begin
          mem_req_o <= 1'b1;
          mem_addr_o <= mem_addr_o + psw_pkg::HALF_STEP;
        end
      end
    end
  end

  // ****************************************************************
  // General registers
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int i = 0; i < 16; i++) begin
        gr[i] <= 32'h0000_0000;
      end
    end else if (gr_we_i) begin
      gr[gr_waddr_i] <= gr_wdata_i;
    end
  end

  // ****************************************************************
  // Current status word
  // ****************************************************************
  // stored on interrupt, new word adopted
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      psw1 <= psw_pkg::PSW1_RST;
      psw2 <= psw_pkg::PSW2_RST;
    end else if (intr_go) begin
      psw1 <= intr_new_psw_i[63:32];
      psw2 <= intr_new_psw_i[31:0];
    end else if (state == ST_DISPATCH) begin
      psw2[psw_pkg::IA_HI:0] <= ia + (len2 ? psw_pkg::FULL_STEP
                                            : psw_pkg::HALF_STEP);
      psw2[psw_pkg::ILC_HI:psw_pkg::ILC_LO] <= len2 ? psw_pkg::ILC_TWO
                                                      : psw_pkg::ILC_ONE;
      if (op_valid && is_branch && br_taken) begin
        psw2[psw_pkg::IA_HI:0] <= br_target & psw_pkg::HALF_ALIGN;
      end
      if (op_valid && is_spm) begin
        psw2[psw_pkg::PMASK_HI:psw_pkg::PMASK_LO] <= gr[r1][27:24];
      end
      if (op_valid && is_svc) begin
        psw1[psw_pkg::ICODE_HI:0] <= {8'h00, ir_hi[7:0]};
      end
    end else if (state == ST_MEM_RD && take_mem && rd_last) begin
      if (is_ssm) begin
        // system mask set touches only bits 0-7
        psw1[psw_pkg::SMASK_HI:psw_pkg::SMASK_LO] <=
          exec_addr_o_lsb ? mem_rdata_i[7:0] : mem_rdata_i[15:8];
      end else begin
        // status load replaces the whole word
        psw1 <= load_buf[47:16];
        psw2 <= {load_buf[15:0], mem_rdata_i};
      end
    end else if (state == ST_EXEC_WAIT && exec_done_i && exec_cc_we_i) begin
      // code written only by code-setting ops
      psw2[psw_pkg::CC_HI:psw_pkg::CC_LO] <= exec_cc_i;
    end else if (state == ST_IO_WAIT && io_done_i) begin
      psw2[psw_pkg::CC_HI:psw_pkg::CC_LO] <= io_cc_i;
    end
  end

  // old word captured at the exchange
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      old_psw_o <= 64'h0;
      intr_ack_o <= 1'b0;
    end else begin
      intr_ack_o <= intr_go;
      if (intr_go) begin
        old_psw_o <= {psw1[31:16], intr_code_i, psw2};
      end
    end
  end

  // ****************************************************************
  // Execution and I/O hand-off
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      exec_start_o <= 1'b0;
      exec_opcode_o <= 8'h00;
      exec_r1_o <= 4'h0;
      exec_r2_o <= 4'h0;
      exec_addr_o <= psw_pkg::ZERO_ADDR;
      exec_fp_o <= 1'b0;
      io_start_o <= 1'b0;
      io_kind_o <= psw_pkg::IO_START;
      io_addr_o <= psw_pkg::ZERO_ADDR;
      prog_check_o <= 1'b0;
      svc_o <= 1'b0;
    end else begin
      exec_start_o <= (state == ST_DISPATCH) && (next_state == ST_EXEC_WAIT);
      // I/O order handed to the channels
      io_start_o <= (state == ST_DISPATCH) && (next_state == ST_IO_WAIT);
      prog_check_o <= (state == ST_DISPATCH) && !op_valid;
      svc_o <= (state == ST_DISPATCH) && op_valid && is_svc;
      if (state == ST_DISPATCH) begin
        exec_opcode_o <= op;
        exec_r1_o <= r1;
        exec_r2_o <= r2;
        exec_addr_o <= op_addr;
        exec_fp_o <= op_fp;
        io_kind_o <= psw_pkg::psw_io_kind_t'(op[1:0]);
        io_addr_o <= op_addr;
      end
    end
  end

  // ****************************************************************
  // Interrupt gating
  // ****************************************************************
  // masked sources stay pending upstream
  // bit 0, 1, 2 channels, bit 7 external
  // machine check passes only with bit 13
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_pend_o <= 8'h00;
      mcheck_irq_o <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        irq_pend_o[i] <= io_pend_i[i] & psw1[psw_pkg::SMASK_HI - i];
      end
      mcheck_irq_o <= mcheck_i & psw1[psw_pkg::MCHK_BIT];
    end
  end

endmodule
`default_nettype wire

// ==== tb/psw_seq_sva.sv ====
// Port checker for the instruction sequencer
`timescale 1ns/100ps
`default_nettype none
module psw_seq_sva (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic mem_req_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic exec_start_o,
  input wire logic exec_done_i,
  input wire logic exec_cc_we_i,
  input wire logic [1:0] exec_cc_i,
  input wire logic io_start_o,
  input wire logic io_done_i,
  input wire logic [1:0] io_cc_i,
  input wire logic [15:0] intr_code_i,
  input wire logic [63:0] intr_new_psw_i,
  input wire logic intr_ack_o,
  input wire logic [63:0] old_psw_o,
  input wire logic [63:0] psw_o,
  input wire logic [7:0] io_pend_i,
  input wire logic [7:0] irq_pend_o,
  input wire logic mcheck_i,
  input wire logic mcheck_irq_o
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  logic busy;
  logic [7:0] mask_rev;

  // Mask bit 0 is the word msb but pending index 0 is the lsb
  assign mask_rev = {<<{psw_o[63:56]}};

  // Only a dispatched operation may answer, stray dones are ignored
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy <= 1'b0;
    end else if (exec_start_o || io_start_o) begin
      busy <= 1'b1;
    end else if (exec_done_i || io_done_i) begin
      busy <= 1'b0;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  property p_irq;
    irq_pend_o == $past(io_pend_i & mask_rev);
  endproperty
  a_irq: assert property (p_irq)
    else $error("pending lines do not follow system mask");
  property p_mchk;
    mcheck_irq_o == $past(mcheck_i & psw_o[50]);
  endproperty
  a_mchk: assert property (p_mchk)
    else $error("machine check gate wrong");
  property p_align;
    mem_req_o |-> !mem_addr_o[0];
  endproperty
  a_align: assert property (p_align)
    else $error("fetch address odd");
  property p_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("storage request not held");
  // A follow-on halfword request may stand at once, at the next address
  property p_drop;
    mem_req_o && mem_ack_i |=> !mem_req_o ||
      mem_addr_o == $past(mem_addr_o) + 24'h00_0002;
  endproperty
  a_drop: assert property (p_drop)
    else $error("storage request not released");
  property p_quiet;
    busy |-> !mem_req_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("fetch while operation outstanding");
  property p_cc_exec;
    busy && exec_done_i && exec_cc_we_i |=>
      psw_o[29:28] == $past(exec_cc_i);
  endproperty
  a_cc_exec: assert property (p_cc_exec)
    else $error("condition code not written");
  property p_cc_keep;
    busy && exec_done_i && !exec_cc_we_i |=> $stable(psw_o[29:28]);
  endproperty
  a_cc_keep: assert property (p_cc_keep)
    else $error("condition code changed");
  property p_cc_io;
    busy && io_done_i |=> psw_o[29:28] == $past(io_cc_i);
  endproperty
  a_cc_io: assert property (p_cc_io)
    else $error("channel code not written");
  property p_new;
    intr_ack_o |-> psw_o == $past(intr_new_psw_i);
  endproperty
  a_new: assert property (p_new)
    else $error("new status word not adopted");
  property p_old;
    intr_ack_o |-> old_psw_o[47:32] == $past(intr_code_i) &&
      old_psw_o[63:48] == $past(psw_o[63:48]);
  endproperty
  a_old: assert property (p_old)
    else $error("old status word wrong");

  c_intr: cover property (intr_ack_o);
  c_io: cover property (busy && io_done_i);
  c_keep: cover property (busy && exec_done_i && !exec_cc_we_i);
endmodule

bind psw_seq psw_seq_sva i_psw_seq_sva (.clock_i, .srst_i, .mem_req_o,
  .mem_addr_o, .mem_ack_i, .exec_start_o, .exec_done_i, .exec_cc_we_i,
  .exec_cc_i, .io_start_o, .io_done_i, .io_cc_i, .intr_code_i,
  .intr_new_psw_i, .intr_ack_o, .old_psw_o, .psw_o, .io_pend_i,
  .irq_pend_o, .mcheck_i, .mcheck_irq_o);
`default_nettype wire

// ==== tb/psw_mem_model.sv ====
// Main storage model answering halfword reads
`timescale 1ns/100ps
`default_nettype none
module psw_mem_model (
  input wire logic clock_i,
  input wire logic mem_req_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [1:0] dly_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  // ****************************************
  // Storage and read answer
  // ****************************************
  logic [15:0] mem [0:511];
  logic [1:0] cnt;

  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 16'h0000;
    cnt = 2'h0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Data toggles outside the answer cycle so stale reads never match
  always @(posedge clock_i) begin
    if (mem_ack_o || !mem_req_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      cnt <= 2'h0;
    end else if (cnt == dly_i) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem[mem_addr_i[9:1]];
    end else begin
      cnt <= cnt + 2'h1;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the instruction sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ****************************************
  // Signals, design and storage
  // ****************************************
  logic clock_i, srst_i, fp_present_i, mem_req_o, mem_ack_i, gr_we_i;
  logic exec_start_o, exec_fp_o, exec_done_i, exec_cc_we_i, io_start_o;
  logic io_done_i, prog_check_o, svc_o, intr_i, intr_ack_o;
  logic mcheck_i, mcheck_irq_o, isio;
  logic [23:0] mem_addr_o, exec_addr_o, io_addr_o;
  logic [15:0] mem_rdata_i, intr_code_i;
  logic [3:0] gr_waddr_i, exec_r1_o, exec_r2_o;
  logic [31:0] gr_wdata_i;
  logic [7:0] exec_opcode_o, io_pend_i, irq_pend_o;
  logic [1:0] exec_cc_i, io_cc_i, dly;
  logic [63:0] intr_new_psw_i, old_psw_o, psw_o;
  psw_pkg::psw_io_kind_t io_kind_o;
  int errors, cmp_count;
  logic [3:0] ga [4] = '{4'h0, 4'h2, 4'h3, 4'h5};
  logic [31:0] gd [4] = '{32'h00ab_cdef, 32'hff00_0010, 32'hffff_fff0,
    32'h0a00_0000};
  logic [31:0] img [$] = '{32'h0000_4112, 32'h0002_3020, 32'h0004_4100,
    32'h0008_1a12, 32'h000a_2a00, 32'h000c_2a00, 32'h000e_8c00,
    32'h0010_0040, 32'h0012_8d00, 32'h0014_0041, 32'h0016_8e00,
    32'h0018_0042, 32'h001a_8f00, 32'h001c_0043, 32'h001e_4740,
    32'h0020_0100, 32'h0022_4710, 32'h0024_0080, 32'h0080_8000,
    32'h0082_00c0, 32'h0084_8200, 32'h0086_00d0, 32'h00c0_a100,
    32'h00d0_0ffd, 32'h00d6_0200, 32'h0200_0450, 32'h0202_0a3c};

  psw_seq i_psw_seq (.clock_i, .srst_i, .fp_present_i, .mem_req_o,
    .mem_addr_o, .mem_ack_i, .mem_rdata_i, .gr_we_i, .gr_waddr_i,
    .gr_wdata_i, .exec_start_o, .exec_opcode_o, .exec_r1_o, .exec_r2_o,
    .exec_addr_o, .exec_fp_o, .exec_done_i, .exec_cc_we_i, .exec_cc_i,
    .io_start_o, .io_kind_o, .io_addr_o, .io_done_i, .io_cc_i,
    .prog_check_o, .svc_o, .intr_i, .intr_code_i, .intr_new_psw_i,
    .intr_ack_o, .old_psw_o, .psw_o, .io_pend_i, .irq_pend_o, .mcheck_i,
    .mcheck_irq_o);
  psw_mem_model i_psw_mem_model (.clock_i, .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .dly_i(dly), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // Executor and channel answer two cycles after each dispatch
  always begin
    @(negedge clock_i);
    if (exec_start_o === 1'b1 || io_start_o === 1'b1) begin
      isio = io_start_o;
      io_cc_i = io_kind_o;
      repeat (2) @(negedge clock_i);
      if (isio) io_done_i = 1'b1;
      else exec_done_i = 1'b1;
      @(negedge clock_i);
      io_done_i = 1'b0;
      exec_done_i = 1'b0;
    end
  end

  task chk(input string nm, input logic [63:0] got, input logic [63:0] ex);
    cmp_count++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Bounded wait for one design event; a miss ends the run
  task step(input int kind, input logic [23:0] a = 24'h0);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 400 && !hit; n++) begin
      @(negedge clock_i);
      case (kind)
        0: hit = exec_start_o === 1'b1;
        1: hit = io_start_o === 1'b1;
        2: hit = prog_check_o === 1'b1;
        3: hit = svc_o === 1'b1;
        4: hit = intr_ack_o === 1'b1;
        5: hit = io_done_i === 1'b1;
        default: hit = mem_req_o === 1'b1 && mem_addr_o === a;
      endcase
    end
    if (!hit) begin
      errors++;
      give_verdict;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task s_addr;
    exec_cc_i = 2'h2;
    exec_cc_we_i = 1'b1;
    step(0);
    chk("rx_addr", exec_addr_o, 24'h000020);
    chk("rx_fields", {exec_opcode_o, exec_r1_o, exec_r2_o}, 16'h4112);
    chk("rx_ia", {psw_o[31:30], psw_o[23:0]}, {2'h2, 24'h4});
    dly = 2'h0;
    step(0);
    chk("zero_addr", exec_addr_o, 24'h0);
    chk("cc_set", psw_o[29:28], 2'h2);
    exec_cc_i = 2'h1;
    exec_cc_we_i = 1'b0;
    step(0);
    chk("cc_keep", psw_o[29:28], 2'h2);
    chk("rr_ia", {psw_o[31:30], psw_o[23:0]}, {2'h1, 24'ha});
  endtask

  task s_fp;
    step(2);
    chk("fp_off", {prog_check_o, psw_o[23:0]}, {1'b1, 24'hc});
    fp_present_i = 1'b1;
    step(0);
    chk("fp_on", {exec_fp_o, exec_opcode_o}, 9'h12a);
  endtask

  task s_io;
    for (int k = 0; k < 4; k++) begin
      step(1);
      chk("io_kind", io_kind_o, k[1:0]);
      chk("io_addr", io_addr_o, 24'h40 + 24'(k));
      // Done rises two falling edges on; code settles one cycle later
      repeat (3) @(negedge clock_i);
      chk("io_cc", psw_o[29:28], k[1:0]);
    end
  endtask

  task s_branch;
    step(6, 24'h22);
    step(6, 24'h80);
    chk("br_cc", psw_o[29:28], 2'h3);
  endtask

  task s_mask;
    io_pend_i = 8'hff;
    step(6, 24'h84);
    repeat (2) @(negedge clock_i);
    chk("smask", psw_o[63:56], 8'ha1);
    chk("smask_cc", psw_o[29:28], 2'h3);
    chk("irq", irq_pend_o, 8'h85);
  endtask

  task s_status;
    step(6, 24'h200);
    chk("load_w1", psw_o[63:32], 32'h0ffd_0000);
    chk("modes", psw_o[51:48], 4'hd);
    chk("load_w2", psw_o[29:0], 30'h200);
    chk("key", psw_o[55:52], 4'hf);
    mcheck_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk("mchk", mcheck_irq_o, 1'b1);
    chk("irq_load", irq_pend_o, 8'hf0);
    mcheck_i = 1'b0;
  endtask

  task s_svc;
    step(3);
    chk("pmask", psw_o[27:24], 4'ha);
    chk("svc", {psw_o[47:32], psw_o[31:30]}, {16'h003c, 2'h1});
    intr_code_i = 16'h003c;
    intr_new_psw_i = 64'h0002_0000_0000_0300;
    intr_i = 1'b1;
    step(4);
    intr_i = 1'b0;
    chk("new_psw", psw_o, 64'h0002_0000_0000_0300);
    chk("old_psw", old_psw_o[63:32], 32'h0ffd_003c);
    repeat (8) @(negedge clock_i);
    chk("wait_idle", {mem_req_o, psw_o[23:0]}, {1'b0, 24'h300});
  endtask

  initial begin
    srst_i = 1'b1;
    {fp_present_i, gr_we_i, exec_done_i, exec_cc_we_i} = 4'h0;
    {io_done_i, intr_i, mcheck_i, isio} = 4'h0;
    {gr_waddr_i, gr_wdata_i, exec_cc_i, io_cc_i} = 40'h0;
    {intr_code_i, intr_new_psw_i, io_pend_i} = 88'h0;
    dly = 2'h3;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(negedge clock_i);
    // Loaded after time zero so the model's own clearing cannot erase it
    foreach (img[i]) i_psw_mem_model.mem[img[i][25:17]] = img[i][15:0];
    chk("psw_reset", psw_o, 64'h0);
    srst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      gr_we_i = 1'b1;
      gr_waddr_i = ga[i];
      gr_wdata_i = gd[i];
      @(negedge clock_i);
    end
    gr_we_i = 1'b0;
    s_addr;
    s_fp;
    s_io;
    s_branch;
    s_mask;
    s_status;
    s_svc;
    give_verdict;
  end
endmodule
`default_nettype wire
